// ---- verilog/fbps_top.sv ----
// Block protection map, sleep entry and release with ID read-out
`timescale 1ns/1ps
module fbps_top
    import fbps_pkg::*;
#(
    parameter logic [7:0]  DEVICE_ID   = DEVICE_ID_DEF, // Arbitrary value
    parameter logic [47:0] FREEZE_INIT = FRZ_RST
) (
    // System clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Serial link
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe,
    // Flash core status
    input  wire logic        busy,
    // Lock query
    input  wire logic [20:0] chk_addr,
    output logic             rd_block,
    output logic             wr_block,
    // Status view
    output logic [47:0]      map_view,
    output logic             asleep,
    output logic             ready,
    output logic             wel
);
    localparam int ENTRY_A_MAX = int'(ENTRY_LOAD) + 3;
    localparam int WAKE_A_MAX  = int'(WAKE_LOAD) + 3;

    // Link domain state
    logic        first_r;
    logic [6:0]  cnt_r;
    logic [6:0]  cnt_nxt;
    logic [7:0]  cmd_r;
    logic [47:0] data_r;
    logic        so_r;
    logic        oe_r;
    logic        rdy_k;
    logic [6:0]  out_idx;
    // System domain state
    logic        cs_s;
    logic        cs_d_r;
    logic        frame_end;
    fbps_frame_t fr;
    fbps_pwr_t   st_r;
    logic [7:0]  tmr_r;
    logic [47:0] map_r;
    logic [47:0] frz_r;
    logic [47:0] map_snap_r;
    logic        wel_r;
    logic        asleep_r;
    logic        ready_r;
    logic        rd_block_r;
    logic        wr_block_r;
    logic        rd_lock;
    logic        wr_lock;
    logic        take_std;
    logic        do_sleep;
    logic        do_release;
    logic        do_write;
    logic        do_unlock;
    logic        do_freeze;
    logic        wel_set;
    logic        wel_clr;

    // Command byte and bit count match
    function automatic logic is_cmd(input fbps_frame_t f, input logic [7:0] c,
                                    input logic [6:0] n);
        return (f.cmd == c) && (f.cnt == n);
    endfunction

    // Map bit for read-out position, zero past the end
    function automatic logic map_bit(input logic [47:0] m, input logic [6:0] idx);
        logic [6:0] pos;
        pos = MAP_MSB - idx;
        return (idx <= MAP_MSB) ? m[pos[5:0]] : 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link domain, clocked by the serial clock

    // Ready level brought over for read gating
    fbps_sync #(
        .RST      (1'b0)
    ) u_rdy_sync (
        .clk      (sck),
        .rstn     (rstn),
        .async_in (ready_r),
        .sync_r   (rdy_k)
    );

    // New-frame flag, held set while chip select is high
    always_ff @(posedge sck or posedge cs_n or negedge rstn) begin
        if (!rstn) begin
            first_r <= 1'b1;
        end else if (cs_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Bit count; long frames wrap in the upper range keeping byte phase
    always_comb begin
        if (first_r) begin
            cnt_nxt = 7'h01;
        end else if (cnt_r == CNT_MAX) begin
            cnt_nxt = CNT_WRAP;
        end else begin
            cnt_nxt = cnt_r + 7'h01;
        end
    end

    // Rising-edge capture of command and data bits
    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            cnt_r  <= '0;
            cmd_r  <= '0;
            data_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            if (first_r || (cnt_r < CNT_CMD)) begin
                cmd_r <= {cmd_r[6:0], si};
            end else begin
                data_r <= {data_r[46:0], si}; // MSB first
            end
        end
    end

    assign out_idx = cnt_r - CNT_CMD;

    // Falling-edge output; map snapshot is static during a frame
    always_ff @(negedge sck or posedge cs_n or negedge rstn) begin
        if (!rstn) begin
            oe_r <= 1'b0;
            so_r <= 1'b0;
        end else if (cs_n) begin
            oe_r <= 1'b0; // Stream ends with the frame
            so_r <= 1'b0;
        end else if (!first_r && (cnt_r >= CNT_CMD) && rdy_k && (cmd_r == CMD_MAP_READ)) begin
            oe_r <= 1'b1;
            so_r <= map_bit(map_snap_r, out_idx);
        end else if (!first_r && (cnt_r >= CNT_ID_START) && (cmd_r == CMD_RELEASE)) begin
            oe_r <= 1'b1;
            so_r <= DEVICE_ID[~cnt_r[2:0]]; // Repeats per byte
        end
    end

    assign so    = so_r;
    assign so_oe = oe_r;

    // Map read pads with zeros
    map_read_a: assert property (@(posedge sck) disable iff (!rstn || cs_n)
        (oe_r && (cmd_r == CMD_MAP_READ) && (cnt_r >= CNT_MAP_FRAME)) |-> !so_r)
        else $error("map read not zero after map");

    ////////////////////////////////////////////////////////////////////////////
    // System domain

    // Chip select level crossing
    fbps_sync #(
        .RST      (1'b1)
    ) u_cs_sync (
        .clk      (sys_clk),
        .rstn     (rstn),
        .async_in (cs_n),
        .sync_r   (cs_s)
    );

    // Frame close detect
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cs_d_r <= 1'b1;
        end else begin
            cs_d_r <= cs_s;
        end
    end

    // Captured frame is quiet once chip select is high
    assign frame_end = cs_s & ~cs_d_r; // Commands run only at close
    assign fr        = {cmd_r, cnt_r, data_r};

    // Command qualification
    assign take_std   = frame_end && (st_r == ST_STANDBY) && !busy;
    assign do_sleep   = take_std && is_cmd(fr, CMD_SLEEP, CNT_CMD);
    assign do_release = frame_end && (fr.cmd == CMD_RELEASE) && (fr.cnt >= CNT_CMD) &&
                        ((st_r == ST_ENTERING) || (st_r == ST_SLEEP));
    assign do_write   = take_std && wel_r && is_cmd(fr, CMD_MAP_WRITE, CNT_MAP_FRAME);
    assign do_unlock  = take_std && wel_r && is_cmd(fr, CMD_UNLOCK, CNT_CMD);
    assign do_freeze  = take_std && wel_r && is_cmd(fr, CMD_FREEZE, CNT_MAP_FRAME);
    assign wel_set    = take_std && is_cmd(fr, CMD_WRITE_ENABLE, CNT_CMD);
    assign wel_clr    = (take_std && is_cmd(fr, CMD_WRITE_DISABLE, CNT_CMD)) ||
                        do_write || do_unlock || do_freeze;

    // Power state machine with entry and wake timers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r  <= ST_STANDBY;
            tmr_r <= '0;
        end else begin
            case (st_r)
                ST_STANDBY: begin
                    if (do_sleep) begin
                        st_r  <= ST_ENTERING;
                        tmr_r <= ENTRY_LOAD;
                    end
                end
                ST_ENTERING: begin
                    if (do_release) begin
                        st_r  <= ST_WAKING;
                        tmr_r <= WAKE_LOAD;
                    end else if (tmr_r == '0) begin
                        st_r <= ST_SLEEP;
                    end else begin
                        tmr_r <= tmr_r - 8'h01;
                    end
                end
                ST_SLEEP: begin
                    if (do_release) begin
                        st_r  <= ST_WAKING;
                        tmr_r <= WAKE_LOAD;
                    end
                end
                ST_WAKING: begin
                    if (tmr_r == '0) begin
                        st_r <= ST_STANDBY;
                    end else begin
                        tmr_r <= tmr_r - 8'h01;
                    end
                end
                default: begin
                    st_r <= ST_STANDBY;
                end
            endcase
        end
    end

    // Registered power status
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            asleep_r <= 1'b0;
            ready_r  <= 1'b1;
        end else begin
            asleep_r <= (st_r == ST_SLEEP);
            ready_r  <= (st_r == ST_STANDBY);
        end
    end

    // Write-enable latch
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wel_r <= 1'b0;
        end else if (wel_set) begin
            wel_r <= 1'b1;
        end else if (wel_clr) begin
            wel_r <= 1'b0;
        end
    end

    // One-time freeze bits, cleared only by reset to FREEZE_INIT
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            frz_r <= FREEZE_INIT;
        end else if (do_freeze) begin
            frz_r <= frz_r | (fr.data & WL_MASK);
        end
    end

    // Protection map; frozen write locks always forced on
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            map_r <= MAP_RST;
        end else if (do_write) begin
            map_r <= fr.data | (frz_r & WL_MASK);
        end else if (do_unlock) begin
            map_r <= map_r & ~(WL_MASK & ~frz_r);
        end else if (do_freeze) begin
            map_r <= map_r | (fr.data & WL_MASK);
        end else begin
            map_r <= map_r | (frz_r & WL_MASK);
        end
    end

    // Snapshot for the link, refreshed only between frames
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            map_snap_r <= MAP_RST;
        end else if (cs_s) begin
            map_snap_r <= map_r;
        end
    end

    // Lock query decode
    fbps_lock_decode u_decode (
        .addr    (chk_addr),
        .map     (map_r),
        .rd_lock (rd_lock),
        .wr_lock (wr_lock)
    );

    // Registered lock answers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_block_r <= 1'b1;
            wr_block_r <= 1'b1;
        end else begin
            rd_block_r <= rd_lock;
            wr_block_r <= wr_lock;
        end
    end

    assign rd_block = rd_block_r;
    assign wr_block = wr_block_r;
    assign map_view = map_r;
    assign asleep   = asleep_r;
    assign ready    = ready_r;
    assign wel      = wel_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_sleep_take;
        frame_end && (st_r == ST_STANDBY) && !busy && is_cmd(fr, CMD_SLEEP, CNT_CMD);
    endsequence

    sequence s_wake_take;
        frame_end && (fr.cmd == CMD_RELEASE) && (fr.cnt >= CNT_CMD) && (st_r == ST_SLEEP);
    endsequence

    sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_sleep_take |-> ##[1:ENTRY_A_MAX] asleep_r)
        else $error("sleep not entered in time");

    sleep_busy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (frame_end && busy && (st_r == ST_STANDBY) && is_cmd(fr, CMD_SLEEP, CNT_CMD))
        |=> (st_r == ST_STANDBY) [*3])
        else $error("sleep taken while busy");

    sleep_ignore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (frame_end && (st_r == ST_SLEEP)) |=> ($stable(map_r) && $stable(wel_r)))
        else $error("command acted on while asleep");

    wake_ready_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_wake_take |-> ##[1:WAKE_A_MAX] ready_r)
        else $error("not ready in time after release");

    unlock_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        do_unlock |=> ((map_r & WL_MASK & ~frz_r) == '0) && ($past(frz_r) == frz_r))
        else $error("unlock left a free write lock");

    map_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        do_write |=> (map_r == (fr.data | (frz_r & WL_MASK))))
        else $error("map write value wrong");

    freeze_once_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        1'b1 |=> ((($past(frz_r) & ~frz_r) == '0) &&
                  ((map_r & frz_r & WL_MASK) == (frz_r & WL_MASK))))
        else $error("frozen lock lost");

    top_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ((chk_addr >= TOP8_BASE) && (chk_addr[BLK8_HI:BLK8_LO] == 2'h3))
        |=> (rd_block_r == $past(map_r[47])) && (wr_block_r == $past(map_r[46])))
        else $error("top block lock answer wrong");

    block64_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ((chk_addr >= BOT32_END) && (chk_addr < TOP32_BASE))
        |=> !rd_block_r && (wr_block_r == $past(map_r[chk_addr[BLK64_HI:BLK64_LO] - 5'h01])))
        else $error("64K block lock answer wrong");

    bottom_pair_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (chk_addr < BOT32_BASE) && (chk_addr[BLK8_HI:BLK8_LO] == 2'h0) ##1
        (chk_addr >= BOT32_BASE) && (chk_addr < BOT32_END)
        |-> (rd_block_r == $past(map_r[33])) && (wr_block_r == $past(map_r[32])) ##1
            !rd_block_r && (wr_block_r == $past(map_r[30])))
        else $error("bottom block lock answer wrong");
endmodule // fbps_top

// ---- common/fbps_pkg.sv ----
// Constants, types and command codes of the block protection and sleep logic
package fbps_pkg;
    // Command bytes taken on the serial link
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_MAP_WRITE     = 8'h42;
    localparam logic [7:0] CMD_MAP_READ      = 8'h72;
    localparam logic [7:0] CMD_UNLOCK        = 8'h98;
    localparam logic [7:0] CMD_FREEZE        = 8'he8;
    localparam logic [7:0] CMD_SLEEP         = 8'hb9;
    localparam logic [7:0] CMD_RELEASE       = 8'hab;

    // Protection map layout
    localparam int          MAP_W   = 48;
    localparam logic [6:0]  MAP_MSB = 7'h2f;
    localparam logic [47:0] MAP_RST = 48'h5555_ffff_ffff;
    localparam logic [47:0] WL_MASK = 48'h5555_ffff_ffff; // Write-lock positions
    localparam logic [47:0] FRZ_RST = 48'h0000_0000_0000;
    localparam logic [5:0]  TOP8_WL_BASE = 6'h28;
    localparam logic [5:0]  BOT8_WL_BASE = 6'h20;
    localparam logic [5:0]  TOP32_WL_BIT = 6'h1f;
    localparam logic [5:0]  BOT32_WL_BIT = 6'h1e;

    // Address ranges of the non-uniform blocks
    localparam int          ADDR_W     = 21;
    localparam logic [20:0] TOP8_BASE  = 21'h1f_8000;
    localparam logic [20:0] TOP32_BASE = 21'h1f_0000;
    localparam logic [20:0] BOT32_BASE = 21'h00_8000;
    localparam logic [20:0] BOT32_END  = 21'h01_0000;
    localparam int          BLK8_LO    = 13;
    localparam int          BLK8_HI    = 14;
    localparam int          BLK64_LO   = 16;
    localparam int          BLK64_HI   = 20;

    // Frame bit counts
    localparam logic [6:0] CNT_CMD       = 7'h08;
    localparam logic [6:0] CNT_ID_START  = 7'h20;
    localparam logic [6:0] CNT_MAP_FRAME = 7'h38;
    localparam logic [6:0] CNT_WRAP      = 7'h40;
    localparam logic [6:0] CNT_MAX       = 7'h7f;

    // Timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int SLEEP_ENTRY_NS  = 3000;
    localparam int WAKE_NS         = 10000;
    localparam int SYNC_LAT        = 6;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     SLEEP_ENTRY_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC        = (WAKE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     WAKE_NS / CLK_PERIOD_NS;
    localparam logic [7:0] ENTRY_LOAD = 8'(SLEEP_ENTRY_CYC - SYNC_LAT);
    localparam logic [7:0] WAKE_LOAD  = 8'(WAKE_CYC - SYNC_LAT);

    // Identification byte, arbitrary value
    localparam logic [7:0] DEVICE_ID_DEF = 8'h5a;

    // Power states
    typedef enum logic [1:0] {ST_STANDBY, ST_ENTERING, ST_SLEEP, ST_WAKING} fbps_pwr_t;

    // One captured frame
    typedef struct packed {
        logic [7:0]  cmd;
        logic [6:0]  cnt;
        logic [47:0] data;
    } fbps_frame_t;
endpackage

// ---- verilog/fbps_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
module fbps_sync #(
    parameter logic RST = 1'b0
) (
    // Destination clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_r
);
    logic meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= RST;
            sync_r <= RST;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end
endmodule // fbps_sync

// ---- verilog/fbps_lock_decode.sv ----
// Address to protection map bit decoder
`timescale 1ns/1ps
module fbps_lock_decode
    import fbps_pkg::*;
(
    // Query
    input  wire logic [20:0] addr,
    input  wire logic [47:0] map,
    // Lock state of the addressed block
    output logic             rd_lock,
    output logic             wr_lock
);
    logic [5:0] wl_idx;
    logic [5:0] rd_idx;
    logic       has_rd;

    // Pick the write-lock bit; read lock sits one above it
    always_comb begin
        has_rd = 1'b0;
        if (addr >= TOP8_BASE) begin
            wl_idx = TOP8_WL_BASE + {3'h0, addr[BLK8_HI:BLK8_LO], 1'b0};
            has_rd = 1'b1;
        end else if (addr >= TOP32_BASE) begin
            wl_idx = TOP32_WL_BIT;
        end else if (addr < BOT32_BASE) begin
            wl_idx = BOT8_WL_BASE + {3'h0, addr[BLK8_HI:BLK8_LO], 1'b0};
            has_rd = 1'b1;
        end else if (addr < BOT32_END) begin
            wl_idx = BOT32_WL_BIT;
        end else begin
            wl_idx = {1'b0, addr[BLK64_HI:BLK64_LO]} - 6'h01;
        end
        rd_idx  = wl_idx + 6'h01;
        rd_lock = has_rd & map[rd_idx];
        wr_lock = map[wl_idx];
    end
endmodule // fbps_lock_decode

// ---- testbench/fbps_host.sv ----
// Host controller model driving the serial link of the protection block
`timescale 1ns/1ps
module fbps_host (
    // Link lines driven by the host
    output logic sck,
    output logic cs_n,
    output logic si,
    // Link lines from the device
    input  wire logic so,
    input  wire logic so_oe
);
    logic oe_seen;

    // Idle link: clock parked low, chip select high
    initial begin
        sck     = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
        oe_seen = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One frame: command, data bits MSB first, then read bits sampled on rising sck
    task automatic frame(input logic [7:0] cmd, input logic [47:0] dat, input int ndat,
                         input int nrd, output logic [63:0] rx);
        logic [55:0] tx;
        int          i;
        tx      = {cmd, dat};
        rx      = '0;
        oe_seen = 1'b0;
        #207 cs_n = 1'b0; // High gap over 160 ns; odd skew keeps link edges off sys_clk
        #40;
        for (i = 0; i < 8 + ndat + nrd; i++) begin
            si = (i < 8 + ndat) ? tx[55-i] : ~si;
            #40 sck = 1'b1;
            if (i >= 8 + ndat) rx = {rx[62:0], so};
            oe_seen = oe_seen | so_oe;
            #40 sck = 1'b0;
        end
        #40 cs_n = 1'b1; // Command only takes effect at frame close
        si = ~si;        // Released data line no longer shows the last bit
    endtask
endmodule // fbps_host

// ---- testbench/fbps_top_test.sv ----
// Self-checking testbench of the block protection and sleep logic
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module fbps_top_test;
    import fbps_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn, sck, cs_n, si, so, so_oe, busy;
    logic [20:0] chk_addr;
    logic        rd_block, wr_block, asleep, ready, wel;
    logic [47:0] map_view, exp_map, frz;
    logic [63:0] rx;
    logic [31:0] lf;
    int          fails, cmp_count, i;

    // Design and host model
    fbps_top uut (.sys_clk(sys_clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(so_oe), .busy(busy), .chk_addr(chk_addr), .rd_block(rd_block),
        .wr_block(wr_block), .map_view(map_view), .asleep(asleep), .ready(ready),
        .wel(wel));
    fbps_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    // System clock, 40 ns period
    always #20 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Pseudo-random source
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected {read lock, write lock} of an address under a map
    function automatic logic [1:0] exp_lock(logic [20:0] a, logic [47:0] m);
        int w;
        if (a >= 21'h1f_8000) w = 40 + 2 * a[14:13];
        else if (a >= 21'h1f_0000) return {1'b0, m[31]};
        else if (a < 21'h00_8000) w = 32 + 2 * a[14:13];
        else if (a < 21'h01_0000) return {1'b0, m[30]};
        else return {1'b0, m[a[20:16] - 1]};
        return {m[w+1], m[w]};
    endfunction

    task close_out;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Send a frame and let the close reach the system clock side
    task cmd(input logic [7:0] c, input logic [47:0] d, input int nd);
        host.frame(c, d, nd, 0, rx);
        cyc(8);
    endtask

    // Bounded wait on asleep (sel 0) or ready (sel 1)
    task wait_sig(input int sel, input logic v, input int lim);
        int n;
        n = 0;
        while (((sel == 0) ? asleep : ready) !== v && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        if (((sel == 0) ? asleep : ready) !== v) begin
            fails++;
            $display("[ERR] state wait sel %0d expected %h timed out", sel, v);
            close_out;
        end
    endtask

    // Query corner addresses and random ones against the expected map
    task run_locks;
        logic [20:0] corners [12];
        logic [1:0]  e;
        // Block 0 followed by the low 32K block exercises the paired query check
        corners = '{21'h0, 21'h00_8000, 21'h1f_e000, 21'h1f_8000, 21'h1f_7fff, 21'h1f_0000,
                    21'h00_ffff, 21'h1f_ffff, 21'h00_7fff, 21'h01_0000, 21'h1e_0000,
                    21'h00_2000};
        for (int k = 0; k < 40; k++) begin
            lf = lfsr_next(lf);
            @(negedge sys_clk) chk_addr = (k < 12) ? corners[k] : lf[20:0];
            @(negedge sys_clk);
            e = exp_lock(chk_addr, exp_map);
            `CHK("rd_block", e[1], rd_block);
            `CHK("wr_block", e[0], wr_block);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung run
    initial begin
        #2ms;
        fails++;
        $display("[ERR] run time expected below limit seen limit");
        close_out;
    end

    // Main sequence
    initial begin
        rstn = 1'b0; busy = 1'b0; chk_addr = '0;
        lf = 32'h2; fails = 0; cmp_count = 0;
        cyc(4);
        rstn = 1'b1;
        cyc(3);
        exp_map = MAP_RST;
        `CHK("map_view", MAP_RST, map_view);
        `CHK("ready", 1'b1, ready);
        run_locks();
        $display("test reset and lock decode done");
        // Write disable clears the latch, so the map write is dropped
        cmd(CMD_WRITE_ENABLE, 48'h0, 0);
        cmd(CMD_WRITE_DISABLE, 48'h0, 0);
        `CHK("wel", 1'b0, wel);
        cmd(CMD_MAP_WRITE, 48'h0, 48);
        `CHK("map_view", exp_map, map_view);
        for (i = 0; i < 3; i++) begin
            lf = lfsr_next(lf);
            exp_map = {lf[15:0], lfsr_next(lf)};
            cmd(CMD_WRITE_ENABLE, 48'h0, 0);
            `CHK("wel", 1'b1, wel);
            cmd(CMD_MAP_WRITE, exp_map, 48);
            `CHK("map_view", exp_map, map_view);
            host.frame(CMD_MAP_READ, 48'h0, 0, 56, rx);
            `CHK("map read", {exp_map, 8'h00}, rx[55:0]);
        end
        run_locks();
        $display("test map write and read done");
        // Unlock, freeze, then clear and unlock cannot release frozen bits
        cmd(CMD_WRITE_ENABLE, 48'h0, 0);
        cmd(CMD_UNLOCK, 48'h0, 0);
        exp_map = exp_map & ~WL_MASK;
        `CHK("map_view", exp_map, map_view);
        frz = 48'h0004_8000_0011;
        cmd(CMD_WRITE_ENABLE, 48'h0, 0);
        cmd(CMD_FREEZE, frz, 48);
        exp_map = exp_map | frz;
        `CHK("map_view", exp_map, map_view);
        cmd(CMD_WRITE_ENABLE, 48'h0, 0);
        cmd(CMD_MAP_WRITE, 48'h0, 48);
        cmd(CMD_WRITE_ENABLE, 48'h0, 0);
        cmd(CMD_UNLOCK, 48'h0, 0);
        exp_map = frz;
        `CHK("map_view", exp_map, map_view);
        run_locks();
        $display("test unlock and freeze done");
        // Sleep refused while busy, then taken
        busy = 1'b1;
        host.frame(CMD_SLEEP, 48'h0, 0, 0, rx);
        cyc(80);
        `CHK("asleep", 1'b0, asleep);
        busy = 1'b0;
        host.frame(CMD_SLEEP, 48'h0, 0, 0, rx);
        wait_sig(0, 1'b1, 75);
        cyc(4);
        `CHK("ready", 1'b0, ready);
        cmd(CMD_WRITE_ENABLE, 48'h0, 0);
        `CHK("wel", 1'b0, wel);
        host.frame(CMD_MAP_READ, 48'h0, 0, 56, rx);
        `CHK("so_oe seen", 1'b0, host.oe_seen);
        // Release with identification read-out, then one more read in standby
        host.frame(CMD_RELEASE, 48'h0, 24, 16, rx);
        wait_sig(1, 1'b1, 250); // Host waits for ready before the next command
        `CHK("asleep", 1'b0, asleep);
        `CHK("id", {DEVICE_ID_DEF, DEVICE_ID_DEF}, rx[15:0]);
        `CHK("so_oe", 1'b0, so_oe);
        host.frame(CMD_RELEASE, 48'h0, 24, 24, rx);
        cyc(8);
        `CHK("id", {3{DEVICE_ID_DEF}}, rx[23:0]);
        `CHK("ready", 1'b1, ready);
        $display("test sleep and release done");
        // Reset in mid-run reloads the default map
        rstn = 1'b0;
        cyc(4);
        rstn = 1'b1;
        cyc(3);
        exp_map = MAP_RST;
        `CHK("map_view", MAP_RST, map_view);
        run_locks();
        $display("test mid-run reset done");
        close_out;
    end
endmodule // fbps_top_test
